/* File: common/usb_hs_defs.svh */
`ifndef USB_HS_DEFS_SVH
`define USB_HS_DEFS_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define HS_IDX_HUB0_CTL      13'h1fa7
`define HS_IDX_FEP0_CTL      13'h1fdd
`define HS_IDX_FEP1_CTL      13'h1fa4
`define HS_IDX_FEP2_CTL      13'h1fa3
`define HS_IDX_FEP3_CTL      13'h1fa2
`define HS_IDX_STS_BASE      13'h1fb0
`define HS_IDX_IRQ_EN        13'h1fb8
`define HS_IDX_ISO_SEL       13'h1fb9

// ----------------------------------------------------------------
// Control and acknowledge fields
// ----------------------------------------------------------------
`define HS_DIR_POS           7
`define HS_LAST_POS          6
`define HS_STALL_POS         5
`define HS_TXRDY_POS         4
`define HS_HALT_ACK_POSITION  3
`define HS_SETUP_ACK_POSITION 2
`define HS_OUT_ACK_POSITION   1
`define HS_IN_ACK_POSITION    0

// ----------------------------------------------------------------
// Service status fields
// ----------------------------------------------------------------
`define HS_ST_HALT_POS       3
`define HS_ST_SETUP_POS      2
`define HS_ST_OUT_POS        1
`define HS_ST_DONE_POS       0

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define HS_CTL_RST           8'h00
`define HS_CFG_RST           5'h00
`define HS_NUM_SLOTS         5

`endif

/* File: common/usb_hs_pkg.sv */
package usb_hs_pkg;

   // Token kinds carried from host to device
   typedef enum logic [1:0] {
      TOK_SETUP = 2'b00,
      TOK_IN    = 2'b01,
      TOK_OUT   = 2'b11
   } tok_kind_e;

   // Answer kinds carried from device to host
   typedef enum logic [1:0] {
      ANS_ACK   = 2'b00,
      ANS_NAK   = 2'b01,
      ANS_STALL = 2'b11,
      ANS_DATA  = 2'b10
   } ans_kind_e;

   // Control transfer phase of a control endpoint
   typedef enum logic [1:0] {
      PH_IDLE   = 2'b00,
      PH_DATA   = 2'b01,
      PH_STATUS = 2'b11
   } ep_phase_e;

   // Host end sequencer
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_TOKEN = 2'b01,
      H_WAIT  = 2'b11
   } host_state_e;

   // Endpoint slot select: 0 hub ep0, 1..4 function ep0..3
   typedef logic [2:0] ep_sel_t;

endpackage : usb_hs_pkg

/* File: common/usb_hs_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface usb_hs_if;
   import usb_hs_pkg::*;

   // Host to device
   logic      tok_valid;  // One-cycle token strobe
   tok_kind_e tok_kind;   // Token kind
   ep_sel_t   tok_ep;     // Addressed endpoint slot
   logic      hs_ack;     // Host ACK after a data packet
   // Device to host
   logic      ans_valid;  // One-cycle answer strobe
   ans_kind_e ans_kind;   // Answer kind
   logic      ans_pid1;   // Data packet is the DATA1 status packet

   modport dev (
      input  tok_valid,
      input  tok_kind,
      input  tok_ep,
      input  hs_ack,
      output ans_valid,
      output ans_kind,
      output ans_pid1
   );

   modport host (
      output tok_valid,
      output tok_kind,
      output tok_ep,
      output hs_ack,
      input  ans_valid,
      input  ans_kind,
      input  ans_pid1
   );
endinterface : usb_hs_if

`default_nettype wire

/* File: hw/usb_ep_slice.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_hs_defs.svh"

module usb_ep_slice import usb_hs_pkg::*; #(
   parameter bit IS_CTRL = 1'b0
) (
   // Clock and reset
   input  wire logic      clk_sys,
   input  wire logic      rst,
   // Firmware write to the control and acknowledge register
   input  wire logic      wr_en,
   input  wire logic [7:0] wdata,
   // Token and handshake from the link
   input  wire logic      tok_hit,
   input  wire tok_kind_e tok_kind,
   input  wire logic      hs_ack,
   // Configuration
   input  wire logic      ie,
   input  wire logic      iso,
   // Readback and decisions
   output logic [7:0]     ctl_rd,
   output logic [7:0]     sts_rd,
   output ans_kind_e      resp_kind,
   output logic           resp_pid1,
   output logic           irq_ev
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic      dir_q;           // Control read when set
   logic      last_q;          // Last packet marker
   logic      stall_q;         // Forced stall
   logic      txrdy_q;         // Packet loaded and ready
   logic      halt_sent_q;     // Stall handshake went out
   logic      setup_q;         // Setup packet received
   logic      out_q;           // OUT data held in the FIFO
   logic      in_done_flag_q;  // IN side completed
   logic      in_wait_q;       // Data packet awaits host ACK
   logic      zlp_wait_q;      // Status packet awaits host ACK
   ep_phase_e phase_q;         // Control transfer phase

   // ----------------------------------------------------------------
   // Token decode
   // ----------------------------------------------------------------
   wire is_setup  = tok_hit & IS_CTRL & (tok_kind == TOK_SETUP);
   wire is_in     = tok_hit & (tok_kind == TOK_IN);
   wire is_out    = tok_hit & (tok_kind == TOK_OUT);
   // Status direction follows the direction bit
   wire status_in = IS_CTRL & ~dir_q & last_q & ~txrdy_q
                    & (phase_q != PH_IDLE);
   wire status_out = IS_CTRL & dir_q & (phase_q == PH_STATUS);

   wire send_stall = (is_in | is_out) & stall_q;
   wire send_data  = is_in & ~stall_q & txrdy_q;
   wire send_zlp   = is_in & ~stall_q & ~txrdy_q & status_in;
   wire take_out   = is_out & ~stall_q & ~out_q;
   wire acked      = hs_ack & in_wait_q;
   wire zlp_acked  = hs_ack & zlp_wait_q;

   // Iso packets set no ACK wait, so ready drops at send
   wire tx_clr   = (send_data & iso) | acked;
   // Final control-read packet and every function IN completion
   wire done_set = (tx_clr & (~IS_CTRL | (dir_q & last_q)))
                   | zlp_acked;
   wire st_done  = zlp_acked | (take_out & status_out);

   // Acknowledge strobes: single-cycle, nothing is stored
   wire ack_halt  = wr_en & wdata[`HS_HALT_ACK_POSITION];
   wire ack_setup = wr_en & wdata[`HS_SETUP_ACK_POSITION];
   wire ack_out   = wr_en & wdata[`HS_OUT_ACK_POSITION];
   wire ack_in    = wr_en & wdata[`HS_IN_ACK_POSITION];

   // ----------------------------------------------------------------
   // Answer selection, stall ahead of everything but SETUP
   // ----------------------------------------------------------------
   always_comb begin
      resp_kind = ANS_NAK;
      resp_pid1 = 1'b0;
      if (is_setup) begin
         resp_kind = ANS_ACK;
      end else if (send_stall) begin
         resp_kind = ANS_STALL;
      end else if (send_data) begin
         resp_kind = ANS_DATA;
      end else if (send_zlp) begin
         // Zero-length DATA1 closes a write or no-data transfer
         resp_kind = ANS_DATA;
         resp_pid1 = 1'b1;
      end else if (take_out) begin
         resp_kind = ANS_ACK;
      end
   end

   // Interrupt events
   assign irq_ev = ie & (take_out | is_setup | st_done
                         | (tx_clr & (done_set | in_done_flag_q)));

   // ----------------------------------------------------------------
   // Firmware-owned fields; a write replaces them
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dir_q   <= 1'b0;
         last_q  <= 1'b0;
         stall_q <= 1'b0;
      end else if (wr_en) begin
         dir_q   <= IS_CTRL & wdata[`HS_DIR_POS];
         last_q  <= wdata[`HS_LAST_POS];  // Kept after status
         stall_q <= wdata[`HS_STALL_POS];
      end
   end

   // Ready: set by firmware, dropped by hardware on iso send or ACK
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txrdy_q <= 1'b0;
      end else if (wr_en) begin
         txrdy_q <= wdata[`HS_TXRDY_POS];
      end else if (tx_clr) begin
         txrdy_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Status flags: hardware set wins over firmware clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         halt_sent_q    <= 1'b0;
         setup_q        <= 1'b0;
         out_q          <= 1'b0;
         in_done_flag_q <= 1'b0;
      end else if (is_setup) begin
         // New setup wipes the other flags
         halt_sent_q    <= 1'b0;
         setup_q        <= 1'b1;
         out_q          <= 1'b0;
         in_done_flag_q <= 1'b0;
      end else begin
         halt_sent_q    <= send_stall | (halt_sent_q & ~ack_halt);
         setup_q        <= setup_q & ~ack_setup;
         out_q          <= take_out | (out_q & ~ack_out);
         in_done_flag_q <= done_set | (in_done_flag_q & ~ack_in);
      end
   end

   // Handshake waits and control phase
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         in_wait_q  <= 1'b0;
         zlp_wait_q <= 1'b0;
         phase_q    <= PH_IDLE;
      end else begin
         in_wait_q  <= (send_data & ~iso) | (in_wait_q & ~hs_ack);
         zlp_wait_q <= send_zlp | (zlp_wait_q & ~hs_ack);
         if (is_setup) begin
            phase_q <= PH_DATA;
         end else if (IS_CTRL & dir_q & last_q & acked) begin
            phase_q <= PH_STATUS;
         end else if (st_done) begin
            phase_q <= PH_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Readback; reserved positions read zero
   // ----------------------------------------------------------------
   assign ctl_rd = {IS_CTRL & dir_q, last_q, stall_q, txrdy_q, 4'h0};
   assign sts_rd = {4'h0, halt_sent_q, IS_CTRL & setup_q, out_q,
                    in_done_flag_q};

endmodule : usb_ep_slice

`default_nettype wire

/* File: hw/usb_hs_dev.sv */
// Operation
// - Done flag after read data, status stages
// - Done flag read-only, cleared by ack bit 0
// - Direction bit 7 selects status phase direction
// - Last plus ready moves to status phase
// - Status completion interrupts; last bit kept
// - Force stall answers IN/OUT with STALL
// - Firmware sets stall for bad requests
// - Ready bit 4 cleared on host ACK
// - Isochronous ready cleared once data sent
// - Firmware fills FIFO only while ready zero
// - Ready clear with done set interrupts
// - Ready drives data and DATA1 status
// - Ack bit 3 clears stall-sent, unstored
// - Ack bit 2 clears setup flag, unstored
// - Ack bits 1,0 clear OUT, done flags
// - Stall-sent flag set after STALL sent
// - OUT flag set; OUT tokens NAKed meanwhile
// - Held OUT data kept except early SETUP
// - OUT flag setting interrupts when enabled
// - Function IN completion sets done flag
// - Function endpoint stall answers STALL
// - SETUP sets setup flag, clears others
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "usb_hs_defs.svh"

module usb_hs_dev import usb_hs_pkg::*; (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [14:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Microcontroller event pulse
   output logic             irq,
   // Link toward the host
   usb_hs_if.dev            link
);

   localparam int NS = `HS_NUM_SLOTS;

   // ----------------------------------------------------------------
   // Control register indices per slot
   // ----------------------------------------------------------------
   localparam logic [12:0] CTL_IDX [NS] = '{
      `HS_IDX_HUB0_CTL,
      `HS_IDX_FEP0_CTL,
      `HS_IDX_FEP1_CTL,
      `HS_IDX_FEP2_CTL,
      `HS_IDX_FEP3_CTL
   };

   // ----------------------------------------------------------------
   // Bus state
   // ----------------------------------------------------------------
   logic        wait_q;     // Waitrequest, low for one cycle
   logic [31:0] rdata_q;    // Captured read word
   logic [NS-1:0] ie_q;     // Per-slot interrupt enable
   logic [NS-1:0] iso_q;    // Per-slot isochronous select
   logic        irq_q;      // Registered event pulse

   // Link answer registers
   logic        ans_valid_q;
   ans_kind_e   ans_kind_q;
   logic        ans_pid1_q;

   // ----------------------------------------------------------------
   // Per-slot wires
   // ----------------------------------------------------------------
   logic [7:0]  ctl_rd   [NS];  // Control readback
   logic [7:0]  sts_rd   [NS];  // Service status readback
   ans_kind_e   resp_kind[NS];  // Slot answer choice
   logic        resp_pid1[NS];  // Slot DATA1 marker
   logic [NS-1:0] irq_ev;       // Slot event pulses
   logic [NS-1:0] hit_ctl;      // Address hits control reg
   logic [NS-1:0] hit_sts;      // Address hits status reg
   logic [NS-1:0] wr_ctl;       // Committed write per slot
   logic [NS-1:0] tok_hit;      // Token addressed to slot

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire [12:0] idx     = avs_address[14:2];
   wire        access  = (avs_read | avs_write) & wait_q;
   // A write lands only at the edge where waitrequest is low
   wire        commit  = avs_write & ~wait_q & avs_byteenable[0];
   wire        hit_ie  = (idx == `HS_IDX_IRQ_EN);
   wire        hit_iso = (idx == `HS_IDX_ISO_SEL);
   wire [7:0]  wbyte   = avs_writedata[7:0];

   // ----------------------------------------------------------------
   // Endpoint slots
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NS; g++) begin : g_slot
      assign hit_ctl[g] = (idx == CTL_IDX[g]);
      assign hit_sts[g] = (idx == 13'(`HS_IDX_STS_BASE + g));
      assign wr_ctl[g]  = commit & hit_ctl[g];
      assign tok_hit[g] = link.tok_valid & (link.tok_ep == ep_sel_t'(g));

      // Slots 0 and 1 are control endpoints
      usb_ep_slice #(
         .IS_CTRL (g < 2)
      ) u_slice (
         .clk_sys   (clk_sys),
         .rst       (rst),
         .wr_en     (wr_ctl[g]),
         .wdata     (wbyte),
         .tok_hit   (tok_hit[g]),
         .tok_kind  (link.tok_kind),
         .hs_ack    (link.hs_ack),
         .ie        (ie_q[g]),
         .iso       (iso_q[g]),
         .ctl_rd    (ctl_rd[g]),
         .sts_rd    (sts_rd[g]),
         .resp_kind (resp_kind[g]),
         .resp_pid1 (resp_pid1[g]),
         .irq_ev    (irq_ev[g])
      );
   end

   // ----------------------------------------------------------------
   // Read multiplexer; unmapped words read zero
   // ----------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_ie) begin
         rd_byte = {3'h0, ie_q};
      end else if (hit_iso) begin
         rd_byte = {3'h0, iso_q};
      end
      for (int i = 0; i < NS; i++) begin
         if (hit_ctl[i]) begin
            rd_byte = ctl_rd[i];
         end
         if (hit_sts[i]) begin
            rd_byte = sts_rd[i];
         end
      end
   end

   // Answer chosen from the addressed slot, NAK when none
   ans_kind_e  ans_kind_d;
   logic       ans_pid1_d;
   always_comb begin
      ans_kind_d = ANS_NAK;
      ans_pid1_d = 1'b0;
      for (int i = 0; i < NS; i++) begin
         if (tok_hit[i]) begin
            ans_kind_d = resp_kind[i];
            ans_pid1_d = resp_pid1[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus handshake: one wait cycle, then the access completes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         // Drop waitrequest for exactly one cycle per access
         wait_q <= ~access;
         if (access) begin
            rdata_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Configuration registers of this block
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ie_q  <= `HS_CFG_RST;
         iso_q <= `HS_CFG_RST;
      end else begin
         if (commit & hit_ie) begin
            ie_q <= wbyte[NS-1:0];
         end
         if (commit & hit_iso) begin
            iso_q <= wbyte[NS-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Link answers, one cycle after each token
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ans_valid_q <= 1'b0;
         ans_kind_q  <= ANS_NAK;
         ans_pid1_q  <= 1'b0;
         irq_q       <= 1'b0;
      end else begin
         ans_valid_q <= link.tok_valid;
         ans_kind_q  <= ans_kind_d;
         ans_pid1_q  <= ans_pid1_d;
         irq_q       <= |irq_ev;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq             = irq_q;
   assign link.ans_valid  = ans_valid_q;
   assign link.ans_kind   = ans_kind_q;
   assign link.ans_pid1   = ans_pid1_q;

endmodule : usb_hs_dev

`default_nettype wire

/* File: hw/usb_hs_host.sv */
`timescale 1ns/1ps
`default_nettype none

module usb_hs_host import usb_hs_pkg::*; (
   // Clock and reset
   input  wire logic      clk_sys,
   input  wire logic      rst,
   // Command port
   input  wire logic      cmd_valid,
   input  wire tok_kind_e cmd_kind,
   input  wire ep_sel_t   cmd_ep,
   output logic           cmd_ready,
   // Result port
   output logic           res_valid,
   output ans_kind_e      res_kind,
   output logic           res_pid1,
   // Link toward the device
   usb_hs_if.host         link
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   host_state_e st_q;        // Sequencer state
   tok_kind_e   kind_q;      // Token being sent
   ep_sel_t     ep_q;        // Endpoint being addressed
   logic        hs_ack_q;    // ACK pulse after a data packet
   logic        res_valid_q; // Result strobe
   ans_kind_e   res_kind_q;  // Result kind
   logic        res_pid1_q;  // Result DATA1 marker

   wire take = (st_q == H_IDLE) & cmd_valid;

   // ----------------------------------------------------------------
   // Sequencer: token, wait for answer, ACK any data packet
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q   <= H_IDLE;
         kind_q <= TOK_SETUP;
         ep_q   <= '0;
      end else begin
         unique case (st_q)
            H_IDLE: begin
               if (take) begin
                  st_q   <= H_TOKEN;
                  kind_q <= cmd_kind;
                  ep_q   <= cmd_ep;
               end
            end
            H_TOKEN: begin
               st_q <= H_WAIT;
            end
            H_WAIT: begin
               if (link.ans_valid) begin
                  st_q <= H_IDLE;
               end
            end
            default: begin
               st_q <= H_IDLE;
            end
         endcase
      end
   end

   // Result capture and data ACK
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hs_ack_q    <= 1'b0;
         res_valid_q <= 1'b0;
         res_kind_q  <= ANS_NAK;
         res_pid1_q  <= 1'b0;
      end else begin
         // Device clears ready on this ACK
         hs_ack_q    <= (st_q == H_WAIT) & link.ans_valid
                        & (link.ans_kind == ANS_DATA);
         res_valid_q <= (st_q == H_WAIT) & link.ans_valid;
         if ((st_q == H_WAIT) & link.ans_valid) begin
            res_kind_q <= link.ans_kind;
            res_pid1_q <= link.ans_pid1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign cmd_ready      = (st_q == H_IDLE);
   assign res_valid      = res_valid_q;
   assign res_kind       = res_kind_q;
   assign res_pid1       = res_pid1_q;
   assign link.tok_valid = (st_q == H_TOKEN);
   assign link.tok_kind  = kind_q;
   assign link.tok_ep    = ep_q;
   assign link.hs_ack    = hs_ack_q;

endmodule : usb_hs_host

`default_nettype wire

/* File: verification/usb_endpoint_handshake_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Link checker between host end and device end
// ----------------------------------------------------------------
module usb_endpoint_handshake_ctrl_properties import usb_hs_pkg::*; (
   // Clock and reset
   input  wire logic      clk_sys,
   input  wire logic      rst,
   // Link signals
   input  wire logic      tok_valid,
   input  wire tok_kind_e tok_kind,
   input  wire ep_sel_t   tok_ep,
   input  wire logic      hs_ack,
   input  wire logic      ans_valid,
   input  wire ans_kind_e ans_kind,
   input  wire logic      ans_pid1
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A data packet went out on the link
   wire data_ans = ans_valid && (ans_kind == ANS_DATA);
   chk_answer_timing: assert property (tok_valid |=> ans_valid)
      else $error("token not answered next cycle");
   chk_answer_cause: assert property (ans_valid |-> $past(tok_valid))
      else $error("answer without token");
   chk_data_acked: assert property (data_ans |=> hs_ack)
      else $error("data packet not acknowledged");
   chk_ack_cause: assert property (hs_ack |-> $past(data_ans))
      else $error("acknowledge without data");
   chk_setup_taken: assert property (
      tok_valid && tok_kind == TOK_SETUP |=> ans_kind == ANS_ACK)
      else $error("setup not accepted");
   chk_pid1_data: assert property (ans_valid && ans_pid1 |-> data_ans)
      else $error("status marker on non-data answer");
   chk_out_no_data: assert property (
      tok_valid && tok_kind == TOK_OUT |=> ans_kind != ANS_DATA)
      else $error("data answer to out token");
   chk_in_no_ack: assert property (
      tok_valid && tok_kind == TOK_IN |=> ans_kind != ANS_ACK)
      else $error("handshake ack to in token");
   // Main scenarios
   cover property (data_ans && ans_pid1);
   cover property (ans_valid && ans_kind == ANS_STALL);
   cover property (ans_valid && ans_kind == ANS_NAK && tok_ep < 3'h5);
endmodule : usb_endpoint_handshake_ctrl_properties
`default_nettype wire

/* File: verification/usb_endpoint_handshake_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_hs_defs.svh"
module usb_endpoint_handshake_ctrl_tb_top import usb_hs_pkg::*;;
   // Stimulus and observed signals
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [14:0] avs_address = 15'h0000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, irq, cmd_ready, res_valid, res_pid1;
   logic        cmd_valid = 1'b0;
   tok_kind_e   cmd_kind = TOK_IN;
   ep_sel_t     cmd_ep = 3'h0;
   ans_kind_e   res_kind;
   int          n_mismatch = 0, comparisons = 0, n_irq = 0, k;
   // Control register word index per slot
   logic [12:0] ci [5] = '{`HS_IDX_HUB0_CTL, `HS_IDX_FEP0_CTL,
      `HS_IDX_FEP1_CTL, `HS_IDX_FEP2_CTL, `HS_IDX_FEP3_CTL};
   usb_hs_if link_if ();
   usb_hs_dev usb_hs_dev_inst (.clk_sys, .rst, .avs_address, .avs_read,
      .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .irq, .link(link_if));
   usb_hs_host usb_hs_host_inst (.clk_sys, .rst, .cmd_valid, .cmd_kind,
      .cmd_ep, .cmd_ready, .res_valid, .res_kind, .res_pid1, .link(link_if));
   usb_endpoint_handshake_ctrl_properties chk_inst (.clk_sys, .rst,
      .tok_valid(link_if.tok_valid), .tok_kind(link_if.tok_kind),
      .tok_ep(link_if.tok_ep), .hs_ack(link_if.hs_ack),
      .ans_valid(link_if.ans_valid), .ans_kind(link_if.ans_kind),
      .ans_pid1(link_if.ans_pid1));
   always #5 clk_sys = ~clk_sys;
   // Pulses last one cycle, so count them rather than poll a level
   always @(posedge clk_sys) if (irq === 1'b1) n_irq <= n_irq + 1;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   // One bus access, held until waitrequest is sampled low
   task automatic rw(input logic w, input logic [12:0] a,
                     input logic [7:0] d, input logic [7:0] e);
      avs_address <= {a, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h000000, d};
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      if (!w) check(avs_readdata[7:0], e);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : rw
   task automatic rc(input int s, input logic [7:0] e);
      rw(1'b0, ci[s], 8'h00, e);
   endtask : rc
   task automatic rs(input int s, input logic [7:0] e);
      rw(1'b0, `HS_IDX_STS_BASE + 13'(s), 8'h00, e);
   endtask : rs
   task automatic wc(input int s, input logic [7:0] d);
      rw(1'b1, ci[s], d, 8'h00);
   endtask : wc
   // One host transaction and its result
   task automatic tok(input tok_kind_e kd, input int ep,
                      input ans_kind_e e, input int p1);
      cmd_kind <= kd;
      cmd_ep <= 3'(ep);
      cmd_valid <= 1'b1;
      do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do @(posedge clk_sys); while (res_valid !== 1'b1);
      check({6'h00, res_kind}, {6'h00, e});
      check({7'h00, res_pid1}, 8'(p1));
   endtask : tok
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rc(i, 8'h00);
         rs(i, 8'h00);
      end
      rw(1'b0, 13'h0040, 8'h00, 8'h00);
      rw(1'b1, `HS_IDX_IRQ_EN, 8'h1f, 8'h00);
      $display("test reset done");
      tok(TOK_SETUP, 1, ANS_ACK, 0);
      rs(1, 8'h04);
      wc(1, 8'h84);
      rs(1, 8'h00);
      wc(1, 8'hd0);
      k = n_irq;
      tok(TOK_IN, 1, ANS_DATA, 0);
      rc(1, 8'hc0);
      rs(1, 8'h01);
      check(8'(n_irq > k), 8'h01);
      tok(TOK_OUT, 1, ANS_ACK, 0);
      rs(1, 8'h03);
      tok(TOK_OUT, 1, ANS_NAK, 0);
      tok(TOK_SETUP, 1, ANS_ACK, 0);
      rs(1, 8'h04);
      wc(1, 8'h07);
      rc(1, 8'h00);
      $display("test control read done");
      tok(TOK_SETUP, 0, ANS_ACK, 0);
      wc(0, 8'h44);
      k = n_irq;
      tok(TOK_IN, 0, ANS_DATA, 1);
      rs(0, 8'h01);
      check(8'(n_irq > k), 8'h01);
      wc(0, 8'h25);
      rs(0, 8'h00);
      tok(TOK_IN, 0, ANS_STALL, 0);
      wc(0, 8'h08);
      $display("test no data stage done");
      wc(2, 8'h20);
      tok(TOK_IN, 2, ANS_STALL, 0);
      tok(TOK_OUT, 2, ANS_STALL, 0);
      rs(2, 8'h08);
      wc(2, 8'h08);
      rs(2, 8'h00);
      k = n_irq;
      tok(TOK_OUT, 3, ANS_ACK, 0);
      rs(3, 8'h02);
      check(8'(n_irq > k), 8'h01);
      tok(TOK_OUT, 3, ANS_NAK, 0);
      wc(3, 8'h12);
      rs(3, 8'h00);
      tok(TOK_IN, 3, ANS_DATA, 0);
      rs(3, 8'h01);
      rc(3, 8'h00);
      $display("test function endpoints done");
      rw(1'b1, `HS_IDX_ISO_SEL, 8'h10, 8'h00);
      wc(4, 8'h10);
      tok(TOK_IN, 4, ANS_DATA, 0);
      rc(4, 8'h00);
      wc(4, 8'hff);
      rc(4, 8'h70);
      tok(TOK_IN, 5, ANS_NAK, 0);
      $display("test iso and reserved done");
      give_verdict();
   end
endmodule : usb_endpoint_handshake_ctrl_tb_top
`default_nettype wire
